// file: verilog/sfpc_pkg.sv
// Constants and types shared by the sector flash host controller.
package sfpc_pkg;

   // ----------------------------------------------------------------
   // Pin widths and host clock
   // ----------------------------------------------------------------
   localparam int ADDR_W    = 19;
   localparam int DATA_W    = 8;
   localparam int SECT_LSB  = 8;    // Sector number sits in addr_bus[18:8].
   localparam int CNT_W     = 20;
   localparam int CLK_NS    = 25;

   // ----------------------------------------------------------------
   // Timing figures and their cycle counts
   // ----------------------------------------------------------------
   localparam int T_ACC_NS  = 90;   // Read access, least wait.
   localparam int T_WE_NS   = 50;   // Write strobe low width, well above the noise filter.
   localparam int T_FILT_NS = 15;   // Strobe noise filter.
   localparam int T_WIN_US  = 150;  // Inter-byte load window, longest.
   localparam int T_TWC_MS  = 10;   // Sector program cycle time.
   localparam int T_PON_MS  = 5;    // Power-on programming lockout.
   localparam int RD_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_CYC    = (T_WE_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_CYC  = (T_FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int WIN_CYC   = (T_WIN_US * 1000) / CLK_NS;
   localparam int TWC_CYC   = (T_TWC_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int PON_CYC   = (T_PON_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int WIN_MARG  = 16;   // Cycles kept spare before the window closes.

   // ----------------------------------------------------------------
   // Command codes of the user port
   // ----------------------------------------------------------------
   localparam logic [2:0] OP_READ   = 3'h0;
   localparam logic [2:0] OP_LOAD   = 3'h1;
   localparam logic [2:0] OP_PREFIX = 3'h2;
   localparam logic [2:0] OP_COMMIT = 3'h3;

   // ----------------------------------------------------------------
   // Sequencer states and full module state
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_POWER = 9'h001,
      ST_IDLE  = 9'h002,
      ST_DISP  = 9'h004,
      ST_WWIN  = 9'h008,
      ST_WSET  = 9'h010,
      ST_WLOW  = 9'h020,
      ST_WEND  = 9'h040,
      ST_RACC  = 9'h080,
      ST_REND  = 9'h100
   } sfpc_state_t;

   typedef struct packed {
      sfpc_state_t         st;
      logic                ce_n;
      logic                oe_n;
      logic                we_n;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dout;
      logic                doe;
      logic [CNT_W-1:0]    cnt;
      logic [CNT_W-1:0]    win;
      logic [CNT_W-1:0]    tmr;
      logic                loading;
      logic                sect_ok;
      logic                prog;
      logic [ADDR_W-1:0]   last_addr;
      logic [DATA_W-1:0]   last_data;
      logic [2:0]          op;
      logic [ADDR_W-1:0]   caddr;
      logic [DATA_W-1:0]   cdata;
      logic [1:0]          pstep;
      logic                pfx;
      logic                polling;
      logic                have6;
      logic                prev6;
      logic                err;
      logic                ready;
      logic                pwr_ok;
      logic                rsp_valid;
      logic [DATA_W-1:0]   rsp_data;
      logic                rsp_err;
   } sfpc_regs_t;

endpackage

// file: verilog/sfpc_host.sv
// Host controller that loads, programs, reads and polls a sector flash device.
//
// Notes on behaviour
// - Load pulses strobe low; address taken last fall.
// - Whole 256-byte sectors; unloaded bytes become ones.
// - Next load falls within 150 us, else programming.
// - Sector bits held at every falling strobe of loaded bytes; prefix strobes use fixed addresses.
// - Three-command prefix enables protection, precedes programs.
// - Host sends protection bytes with load timing.
`timescale 1ns/1ps
module sfpc_host
   import sfpc_pkg::*;
#(
   parameter int                      WIN_CYCLES = sfpc_pkg::WIN_CYC,
   parameter int                      TWC_CYCLES = sfpc_pkg::TWC_CYC,
   parameter int                      PON_CYCLES = sfpc_pkg::PON_CYC,
   parameter logic [sfpc_pkg::ADDR_W-1:0] PFX_ADDR0 = 19'h00001,
   parameter logic [sfpc_pkg::ADDR_W-1:0] PFX_ADDR1 = 19'h00002,
   parameter logic [sfpc_pkg::ADDR_W-1:0] PFX_ADDR2 = 19'h00003,
   parameter logic [sfpc_pkg::DATA_W-1:0] PFX_DATA0 = 8'h01,
   parameter logic [sfpc_pkg::DATA_W-1:0] PFX_DATA1 = 8'h02,
   parameter logic [sfpc_pkg::DATA_W-1:0] PFX_DATA2 = 8'h03
) (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst,
   // User command port
   input  wire logic                        cmd_valid,
   input  wire logic [2:0]                  cmd_op,
   input  wire logic [sfpc_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [sfpc_pkg::DATA_W-1:0] cmd_data,
   output logic                             cmd_ready,
   // User answer port
   output logic                             rsp_valid,
   output logic [sfpc_pkg::DATA_W-1:0]      rsp_data,
   output logic                             rsp_error,
   output logic                             loading,
   output logic                             programming,
   // Flash pins
   output logic                             flash_ce_n,
   output logic                             flash_oe_n,
   output logic                             flash_we_n,
   output logic [sfpc_pkg::ADDR_W-1:0]      addr_bus,
   input  wire logic [sfpc_pkg::DATA_W-1:0] data_in,
   output logic [sfpc_pkg::DATA_W-1:0]      data_out,
   output logic                             data_oe
);
   import sfpc_pkg::*;

   sfpc_regs_t r_reg;
   sfpc_regs_t r_next;
   logic       same_sect;
   logic       win_late;
   logic       poll_done;

   // ----------------------------------------------------------------
   // Decisions used by the sequencer
   // ----------------------------------------------------------------
   // A load is refused into the open window once too little time is left,
   // since a late strobe would land after the device has started programming.
   assign same_sect = (r_reg.caddr[ADDR_W-1:SECT_LSB] == r_reg.last_addr[ADDR_W-1:SECT_LSB]);
   assign win_late  = (r_reg.win >= CNT_W'(WIN_CYCLES - WIN_MARG));
   // Done once bit 7 reads true and bit 6 has stopped toggling.
   assign poll_done = (r_reg.rsp_data[7] == r_reg.last_data[7]) && r_reg.have6 &&
                      (r_reg.rsp_data[6] == r_reg.prev6);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      r_next           = r_reg;
      r_next.rsp_valid = 1'b0;
      // Load window runs from the last rising strobe; expiry means programming.
      if (r_reg.loading) begin
         r_next.win = r_reg.win + CNT_W'(1);
         if (r_reg.win >= CNT_W'(WIN_CYCLES)) begin
            r_next.loading = 1'b0;
            r_next.sect_ok = 1'b0;
            r_next.prog    = 1'b1;
            r_next.tmr     = '0;
         end
      end
      if (r_reg.prog && r_reg.tmr != {CNT_W{1'b1}}) begin
         r_next.tmr = r_reg.tmr + CNT_W'(1);
      end
      case (r_reg.st)
         ST_POWER: begin
            // No strobe at all until the power-on lockout has surely run out.
            r_next.cnt = r_reg.cnt + CNT_W'(1);
            if (r_reg.cnt >= CNT_W'(PON_CYCLES - 1)) begin
               r_next.pwr_ok = 1'b1;
               r_next.ready  = 1'b1;
               r_next.st     = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (cmd_valid && r_reg.ready) begin
               r_next.op    = cmd_op;
               r_next.caddr = cmd_addr;
               r_next.cdata = cmd_data;
               r_next.ready = 1'b0;
               r_next.st    = ST_DISP;
            end
         end
         ST_DISP: begin
            if (r_reg.prog) begin
               // Busy device: every command first polls the last loaded byte.
               r_next.polling = 1'b1;
               r_next.have6   = 1'b0;
               r_next.addr    = r_reg.last_addr;
               r_next.ce_n    = 1'b0;
               r_next.oe_n    = 1'b0;
               r_next.cnt     = '0;
               r_next.st      = ST_RACC;
            end else if (r_reg.loading &&
                         (r_reg.op == OP_READ || r_reg.op == OP_COMMIT || win_late ||
                          (r_reg.op == OP_LOAD && r_reg.sect_ok && !same_sect))) begin
               // Let the window close rather than read, commit, load late or change sector into it.
               r_next.st = ST_WWIN;
            end else if (r_reg.op == OP_READ) begin
               r_next.polling = 1'b0;
               r_next.addr    = r_reg.caddr;
               r_next.ce_n    = 1'b0;
               r_next.oe_n    = 1'b0;
               r_next.cnt     = '0;
               r_next.st      = ST_RACC;
            end else if (r_reg.op == OP_LOAD || r_reg.op == OP_PREFIX) begin
               r_next.pfx   = (r_reg.op == OP_PREFIX);
               r_next.pstep = 2'h0;
               r_next.addr  = (r_reg.op == OP_PREFIX) ? PFX_ADDR0 : r_reg.caddr;
               r_next.dout  = (r_reg.op == OP_PREFIX) ? PFX_DATA0 : r_reg.cdata;
               r_next.ce_n  = 1'b0;
               r_next.doe   = 1'b1;
               r_next.st    = ST_WSET;
            end else begin
               r_next.rsp_valid = 1'b1;
               r_next.rsp_data  = '0;
               r_next.rsp_err   = r_reg.err;
               r_next.err       = 1'b0;
               r_next.ready     = 1'b1;
               r_next.st        = ST_IDLE;
            end
         end
         ST_WWIN: begin
            if (!r_reg.loading) begin
               r_next.st = ST_DISP;
            end
         end
         ST_WSET: begin
            // Select and data settle one cycle before the strobe falls.
            r_next.we_n = 1'b0;
            r_next.cnt  = '0;
            r_next.st   = ST_WLOW;
         end
         ST_WLOW: begin
            r_next.cnt = r_reg.cnt + CNT_W'(1);
            if (r_reg.cnt >= CNT_W'(WE_CYC - 1)) begin
               r_next.we_n = 1'b1;
               r_next.st   = ST_WEND;
            end
         end
         ST_WEND: begin
            r_next.loading = 1'b1;
            r_next.win     = '0;
            if (!r_reg.pfx) begin
               r_next.last_addr = r_reg.addr;
               r_next.last_data = r_reg.dout;
               r_next.sect_ok   = 1'b1;
            end
            if (r_reg.pfx && r_reg.pstep != 2'h2) begin
               // Prefix bytes go out back to back under one select.
               r_next.pstep = r_reg.pstep + 2'h1;
               r_next.addr  = (r_reg.pstep == 2'h0) ? PFX_ADDR1 : PFX_ADDR2;
               r_next.dout  = (r_reg.pstep == 2'h0) ? PFX_DATA1 : PFX_DATA2;
               r_next.st    = ST_WSET;
            end else begin
               r_next.ce_n      = 1'b1;
               r_next.doe       = 1'b0;
               r_next.rsp_valid = 1'b1;
               r_next.rsp_err   = r_reg.err;
               r_next.err       = 1'b0;
               r_next.ready     = 1'b1;
               r_next.st        = ST_IDLE;
            end
         end
         ST_RACC: begin
            r_next.cnt = r_reg.cnt + CNT_W'(1);
            if (r_reg.cnt >= CNT_W'(RD_CYC - 1)) begin
               r_next.rsp_data = data_in;
               r_next.ce_n     = 1'b1;
               r_next.oe_n     = 1'b1;
               r_next.st       = ST_REND;
            end
         end
         ST_REND: begin
            if (!r_reg.polling) begin
               r_next.rsp_valid = 1'b1;
               r_next.rsp_err   = r_reg.err;
               r_next.err       = 1'b0;
               r_next.ready     = 1'b1;
               r_next.st        = ST_IDLE;
            end else if (poll_done || r_reg.tmr >= CNT_W'(TWC_CYCLES)) begin
               // A device that overruns its cycle time is flagged, not waited on.
               r_next.err     = !poll_done;
               r_next.prog    = 1'b0;
               r_next.polling = 1'b0;
               r_next.st      = ST_DISP;
            end else begin
               r_next.have6 = 1'b1;
               r_next.prev6 = r_reg.rsp_data[6];
               r_next.ce_n  = 1'b0;
               r_next.oe_n  = 1'b0;
               r_next.cnt   = '0;
               r_next.st    = ST_RACC;
            end
         end
         default: r_next.st = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         r_reg      <= '0;
         r_reg.st   <= ST_POWER;
         r_reg.ce_n <= 1'b1;
         r_reg.oe_n <= 1'b1;
         r_reg.we_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register.
   assign cmd_ready   = r_reg.ready;
   assign rsp_valid   = r_reg.rsp_valid;
   assign rsp_data    = r_reg.rsp_data;
   assign rsp_error   = r_reg.rsp_err;
   assign loading     = r_reg.loading;
   assign programming = r_reg.prog;
   assign flash_ce_n  = r_reg.ce_n;
   assign flash_oe_n  = r_reg.oe_n;
   assign flash_we_n  = r_reg.we_n;
   assign addr_bus    = r_reg.addr;
   assign data_out    = r_reg.dout;
   assign data_oe     = r_reg.doe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_rd_open;
      $fell(flash_oe_n) && !flash_ce_n;
   endsequence
   sequence s_rd_hold;
      (!flash_oe_n && !flash_ce_n && flash_we_n)[*4];
   endsequence

   a_read_access: assert property (s_rd_open |-> s_rd_hold)
      else $error("read strobe shorter than access time");
   a_no_contention: assert property (data_oe |-> flash_oe_n)
      else $error("host drives data while output enable low");
   a_write_inhibit: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n && data_oe)
      else $error("write strobe low outside a legal load");
   a_strobe_width: assert property ($fell(flash_we_n) |-> ##1 !flash_we_n)
      else $error("write strobe pulse too short");
   a_data_held: assert property (!flash_we_n ##1 flash_we_n |-> $stable(data_out) && data_oe)
      else $error("data changed at rising strobe");
   a_window_kept: assert property ($fell(flash_we_n) && r_reg.loading |->
                                    r_reg.win < CNT_W'(WIN_CYCLES))
      else $error("load strobe after window closed");
   a_sector_held: assert property ($fell(flash_we_n) && r_reg.sect_ok && !r_reg.pfx |->
                                    addr_bus[18:8] == r_reg.last_addr[18:8])
      else $error("sector changed inside a load");
   a_no_load_busy: assert property (programming |-> flash_we_n)
      else $error("write strobe while device programs");
   a_power_lock: assert property (!flash_we_n |-> r_reg.pwr_ok)
      else $error("write before power-on delay");
   a_poll_bound: assert property (r_reg.polling |-> r_reg.tmr <= CNT_W'(TWC_CYCLES + 8))
      else $error("polling ran past program cycle time");
   a_prefix_three: assert property ($rose(r_reg.pfx) |->
                                     ##[1:20] (r_reg.pstep == 2'h2) && !flash_we_n)
      else $error("prefix sequence incomplete");

endmodule

// file: bench/sfpc_flash_model.sv
// Behavioural model of the sector flash device facing the host controller.
`timescale 1ns/1ps
module sfpc_flash_model #(
   parameter int WIN  = 200,
   parameter int BUSY = 300,
   parameter int PON  = 20,
   parameter logic [7:0] ID_MAKER = 8'h6d,   // Arbitrary maker code.
   parameter logic [7:0] ID_PART  = 8'h72,   // Arbitrary part code.
   parameter logic [7:0] ID_ENTER = 8'h90    // Arbitrary identification entry code.
) (
   // Host clock and power-up reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Flash pins, din is the resolved data wire
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [18:0] a,
   input  wire logic [7:0]  din,
   output logic      [7:0]  dq
);
   // -------------------------------------------------------------
   // Array, load latches and timers
   // -------------------------------------------------------------
   logic [7:0]   mem [int];
   logic [7:0]   ld [256];
   logic [255:0] ldv = '0;
   logic [7:0]   q = 8'h00;
   logic [7:0]   last_d = 8'h00;
   logic [18:0]  la;
   logic [10:0]  sect;
   logic         loading = 1'b0;
   logic         prot = 1'b0;     // Shipped with protection off.
   logic         tog = 1'b0;
   logic         armed = 1'b0;
   // Only the software entry is reachable: this host has no high-voltage address pin,
   // so both identification paths share one code table.
   logic         ident = 1'b0;
   int           win = 0;
   int           busy = 0;
   int           pon = 0;
   int           npfx = 0;
   realtime      t0;

   // A released bus shows the inverse of the last byte, so stale data never passes.
   assign dq = (!ce_n && !oe_n && we_n) ? q : ~q;

   // End of loading: protection is judged here, then the sector is rewritten whole.
   task automatic start_prog();
      loading = 1'b0;
      busy = BUSY;
      if (npfx == 3) prot = 1'b1;
      if (pon >= PON && (!prot || npfx == 3) && ldv != '0) begin
         for (int i = 0; i < 256; i++) begin
            mem[int'({sect, i[7:0]})] = ldv[i] ? ld[i] : 8'hff;
         end
      end
      ldv = '0;
      npfx = 0;
   endtask

   // Strobe fall takes the address; a busy device or enabled output inhibits the load.
   always @(negedge we_n) begin
      #1;
      armed = !ce_n && oe_n && busy == 0;
      la = a;
      t0 = $realtime - 1.0;
   end

   // First rising strobe takes the data, unless the pulse was noise.
   always @(posedge we_n) begin
      if (armed && $realtime - t0 >= 15.0) begin
         if (ldv == '0 && npfx < 3 && la == 19'(npfx + 1) && din == 8'(npfx + 1)) begin
            npfx++;
         end else if (ldv == '0 && npfx == 2 && la == 19'h00003 && din == ID_ENTER) begin
            ident = 1'b1;
            npfx = 0;
         end else begin
            sect = la[18:8];
            ld[la[7:0]] = din;
            ldv[la[7:0]] = 1'b1;
         end
         last_d = din;
         loading = 1'b1;
         win = 0;
      end
      armed = 1'b0;
   end

   // A read while busy is a poll; a read inside the window ends loading.
   always @(negedge oe_n) begin
      #1;
      if (!ce_n && we_n) begin
         if (loading) start_prog();
         if (busy > 0) begin
            tog = ~tog;
            q = {~last_d[7], tog, last_d[5:0]};
         end else if (ident && a[18:1] == 18'h0) begin
            q = a[0] ? ID_PART : ID_MAKER;
         end else begin
            q = mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
         end
      end
   end

   // Power-on lockout, program timer and load window.
   always @(posedge clock) begin
      if (rst) pon = 0;
      else if (pon < PON) pon++;
      if (busy > 0) busy--;
      if (loading && we_n) begin
         win++;
         if (win >= WIN) start_prog();
      end
   end
endmodule

// file: bench/sector_flash_program_control_tb_top.sv
// Self-checking testbench of the sector flash host controller.
`timescale 1ns/1ps
module sector_flash_program_control_tb_top;
   import sfpc_pkg::*;
   logic        clock, rst, cmd_valid, cmd_ready, rsp_valid, rsp_error;
   logic        loading, programming, ce_n, oe_n, we_n, data_oe, e, pg;
   logic [2:0]  cmd_op;
   logic [18:0] cmd_addr, addr_bus;
   logic [7:0]  cmd_data, rsp_data, data_out, dev_dq, bus, r;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cyc;
   // Identification codes are arbitrary values shared with the device model.
   localparam logic [7:0] ID_MAKER = 8'h6d;
   localparam logic [7:0] ID_PART  = 8'h72;
   localparam logic [7:0] ID_ENTER = 8'h90;

   // The host wins the data wire only while it enables its drivers.
   assign bus = data_oe ? data_out : dev_dq;

   sfpc_host #(.WIN_CYCLES(200), .TWC_CYCLES(500), .PON_CYCLES(20)) uut (
      .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
      .loading(loading), .programming(programming), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n), .addr_bus(addr_bus),
      .data_in(bus), .data_out(data_out), .data_oe(data_oe));

   sfpc_flash_model #(.ID_MAKER(ID_MAKER), .ID_PART(ID_PART), .ID_ENTER(ID_ENTER)) dev (
      .clock(clock), .rst(rst), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .a(addr_bus), .din(bus), .dq(dev_dq));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // Offers one command on a falling edge and waits, bounded, for its answer.
   task automatic cmd(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
      pg = 1'b0;
      for (int k = 0; k < 60 && cmd_ready !== 1'b1; k++) @(negedge clock);
      if (cmd_ready !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: never ready", $time);
         conclude();
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      for (cyc = 0; cyc < 3000; cyc++) begin
         @(negedge clock);
         // Lowered once only, so a following command can raise it at its answer edge.
         if (cyc == 0) cmd_valid = 1'b0;
         pg = pg | programming;
         if (rsp_valid === 1'b1) break;
      end
      r = rsp_data;
      e = rsp_error;
      if (cyc == 3000) begin
         miscompares++;
         $display("unexpected at %0t: no answer", $time);
         conclude();
      end
   endtask

   task automatic rd(input logic [18:0] a, input logic [7:0] exp);
      cmd(OP_READ, a, 8'h00);
      check(r, exp);
   endtask

   task automatic commit();
      cmd(OP_COMMIT, 19'h0, 8'h00);
      check({6'h0, e, pg}, 8'h01);
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_load_order();
      cmd(OP_LOAD, 19'h00507, 8'h5a);
      check(8'(cyc), 8'h05);
      check({7'h0, loading}, 8'h01);
      cmd(OP_LOAD, 19'h00502, 8'ha5);
      cmd(OP_LOAD, 19'h005ff, 8'h80);
      commit();
      rd(19'h00507, 8'h5a);
      check(8'(cyc), 8'h06);
      rd(19'h00502, 8'ha5);
      rd(19'h005ff, 8'h80);
      rd(19'h00500, 8'hff);
      $display("test load_order done");
   endtask

   // Reprogramming one byte leaves the rest of the sector erased.
   task automatic t_reerase();
      cmd(OP_LOAD, 19'h00502, 8'h3c);
      commit();
      rd(19'h00507, 8'hff);
      rd(19'h00502, 8'h3c);
      $display("test reerase done");
   endtask

   // A load to another sector waits out the window; a read inside it follows the poll.
   task automatic t_poll_read();
      cmd(OP_LOAD, 19'h00a10, 8'h7e);
      cmd(OP_LOAD, 19'h00b10, 8'hc3);
      check({6'h0, e, pg}, 8'h01);
      cmd(OP_READ, 19'h00b10, 8'h00);
      check(r, 8'hc3);
      check({6'h0, e, pg}, 8'h01);
      rd(19'h00a10, 8'h7e);
      $display("test poll_read done");
   endtask

   // Software identification entry, then both codes read back.
   task automatic t_ident();
      cmd(OP_LOAD, 19'h00001, 8'h01);
      cmd(OP_LOAD, 19'h00002, 8'h02);
      cmd(OP_LOAD, 19'h00003, ID_ENTER);
      cmd(OP_READ, 19'h00000, 8'h00);
      check(r, ID_MAKER);
      check({6'h0, e, pg}, 8'h01);
      rd(19'h00001, ID_PART);
      $display("test ident done");
   endtask

   // Prefixed writes land; an unprefixed write times but changes nothing.
   task automatic t_protect();
      cmd(OP_PREFIX, 19'h0, 8'h00);
      cmd(OP_LOAD, 19'h00c00, 8'h11);
      commit();
      rd(19'h00c00, 8'h11);
      cmd(OP_LOAD, 19'h00c00, 8'h22);
      commit();
      rd(19'h00c00, 8'h11);
      cmd(OP_PREFIX, 19'h0, 8'h00);
      cmd(OP_LOAD, 19'h00c01, 8'h33);
      commit();
      rd(19'h00c01, 8'h33);
      rd(19'h00c00, 8'hff);
      $display("test protect done");
   endtask

   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_addr = 19'h0;
      cmd_data = 8'h00;
      repeat (12) @(negedge clock);
      check({4'h0, ce_n, oe_n, we_n, data_oe}, 8'h0e);
      rst = 1'b0;
      t_load_order();
      t_reerase();
      t_poll_read();
      t_protect();
      t_ident();
      conclude();
   end
endmodule
